// ---- rtl/poc_pkg.sv ----
package poc_pkg;

	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned NUM_CH    = 3;
	localparam int unsigned OFS_W     = 10;
	localparam int unsigned LT_W      = 14;
	localparam int unsigned PH_W      = 6;
	localparam int unsigned LINE_W    = 12;
	localparam int unsigned SMP_W     = 10;

	// Register offsets
	localparam logic [7:0] A_RED_OFS_HI   = 8'h18;
	localparam logic [7:0] A_RED_OFS_LO   = 8'h19;
	localparam logic [7:0] A_GRN_OFS_HI   = 8'h1a;
	localparam logic [7:0] A_GRN_OFS_LO   = 8'h1b;
	localparam logic [7:0] A_BLU_OFS_HI   = 8'h1c;
	localparam logic [7:0] A_BLU_OFS_LO   = 8'h1d;
	localparam logic [7:0] A_LT_HI        = 8'h1e;
	localparam logic [7:0] A_LT_LO        = 8'h1f;
	localparam logic [7:0] A_PHASE        = 8'h20;
	localparam logic [7:0] A_COAST_BEFORE = 8'h21;
	localparam logic [7:0] A_COAST_AFTER  = 8'h22;
	localparam logic [7:0] A_PLL_OPT      = 8'h23;
	localparam logic [7:0] A_RST_HI       = 8'h24;
	localparam logic [7:0] A_RST_LO       = 8'h25;
	localparam logic [7:0] A_CLAMP_W      = 8'h26;
	localparam logic [7:0] A_COMP_CFG     = 8'h27;

	// Reset values
	localparam logic [7:0] R_OFS_HI       = 8'h80;
	localparam logic [7:0] R_OFS_LO       = 8'h00;
	localparam logic [7:0] R_LT_HI        = 8'h06;
	localparam logic [7:0] R_LT_LO        = 8'h98;
	localparam logic [7:0] R_PHASE        = 8'h00;
	localparam logic [7:0] R_COAST        = 8'h04;
	localparam logic [7:0] R_PLL_OPT      = 8'h00;
	localparam logic [7:0] R_RST_HI       = 8'h00;
	localparam logic [7:0] R_RST_LO       = 8'h02;
	localparam logic [7:0] R_CLAMP_W      = 8'h10;
	localparam logic [7:0] R_COMP_CFG     = 8'h40;

	// Field layout
	localparam int unsigned OFS_LO_MSB    = 7;
	localparam int unsigned OFS_LO_LSB    = 6;
	localparam int unsigned HI6_MSB       = 5;
	localparam int unsigned OPT_LOCK_LEAD = 0;
	localparam int unsigned OPT_INV_EN    = 1;
	localparam int unsigned OPT_EXT_COAST = 2;
	localparam int unsigned OPT_COAST_POL = 3;
	localparam int unsigned OPT_EXT_CLK   = 4;
	localparam int unsigned OPT_MSB       = 4;
	localparam int unsigned CFG_COMP_OFF  = 0;

	// Offset word value meaning zero offset / mid DAC
	localparam logic [OFS_W-1:0] OFS_MID  = 10'h200;
	localparam logic [SMP_W-1:0] SMP_MAX  = 10'h3ff;

	typedef enum logic [1:0] {
		POC_IDLE  = 2'b00,
		POC_WAIT  = 2'b01,
		POC_CLAMP = 2'b10
	} poc_clamp_e;

endpackage

// ---- rtl/poc_ctrl.sv ----
// How it works
// - Low offset registers hold offset word bits 1:0 in bits 7:6.
// - Compensation off: upper offset byte drives each channel's DAC.
// - Compensation on: offset word becomes a digital sample offset.
// - 0x80 with zero low bits is mid DAC or zero digital offset.
// - Line total is 14 bits; PLL takes it only on low byte write.
// - Six-bit phase moves sample point by 1/64 pixel per step.
// - Internal coast starts the programmed lines before vsync once a frame length is learned.
// - Internal coast lasts the programmed lines after vsync ends.
// - Lock edge bit: clear trailing hsync edge, set leading edge.
// - Clock invert enable: clear ignores the invert pin, set obeys.
// - Coast source bit: clear internal coast, set external input.
// - External coast polarity: clear active high, set active low.
// - Pixel clock bit: clear internal PLL, set external clock pin.
// - Restore and black level start at 14-bit pixel after hsync.
// - Clamp width only shapes the DC restore clamp.
// - Clamp width zero never connects the clamp DAC.
// - Disable bit: clear digital offset, set DACs with same delay.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none

module poc_ctrl
	import poc_pkg::*;
(
	input  wire logic                         clk_sys,
	input  wire logic                         rst_n,
	input  wire logic [ADDR_W-1:0]            reg_addr,
	input  wire logic [DATA_W-1:0]            reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [DATA_W-1:0]            reg_rdata,
	input  wire logic                         hsync,
	input  wire logic                         raw_hsync,
	input  wire logic                         vsync,
	input  wire logic                         ext_coast_in,
	input  wire logic                         clock_invert_input,
	input  wire logic                         dpll_pixel_tick,
	input  wire logic                         external_pixel_clock_input,
	input  wire logic [NUM_CH-1:0][SMP_W-1:0] sample_in,
	input  wire logic                         sample_in_valid,
	output logic      [NUM_CH-1:0][SMP_W-1:0] sample_out,
	output logic                              sample_out_valid,
	output logic      [NUM_CH-1:0][7:0]       dac_offset,
	output logic      [LT_W-1:0]              pll_line_total,
	output logic      [PH_W-1:0]              pll_phase,
	output logic                              pll_lock_pulse,
	output logic                              pll_coast,
	output logic                              pixel_clock_invert,
	output logic                              pixel_clock_external,
	output logic                              pixel_tick,
	output logic                              blc_start_pulse,
	output logic                              clamp_connect
);

	logic [NUM_CH-1:0][7:0] ofs_hi_q;
	logic [NUM_CH-1:0][1:0] ofs_lo_q;
	logic [HI6_MSB:0]       lt_hi_q;
	logic [LT_W-1:0]        lt_q;
	logic [PH_W-1:0]        phase_q;
	logic [7:0]             coast_before_q;
	logic [7:0]             coast_after_q;
	logic [OPT_MSB:0]       opt_q;
	logic [HI6_MSB:0]       rst_hi_q;
	logic [7:0]             rst_lo_q;
	logic [7:0]             clamp_w_q;
	logic [7:0]             cfg_q;
	logic [DATA_W-1:0]      rdata_q;
	logic                   comp_on;

	assign comp_on = ~cfg_q[CFG_COMP_OFF];

	// Offset word index decode: returns channel for a high/low address
	function automatic logic [1:0] ofs_chan(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] d;
		d = a - A_RED_OFS_HI;
		return d[2:1];
	endfunction

	function automatic logic is_ofs(input logic [ADDR_W-1:0] a);
		return (a >= A_RED_OFS_HI) && (a <= A_BLU_OFS_LO);
	endfunction

	// Offset registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				ofs_hi_q[i] <= R_OFS_HI;
				ofs_lo_q[i] <= R_OFS_LO[OFS_LO_MSB:OFS_LO_LSB];
			end
		end else if (reg_wr && is_ofs(reg_addr)) begin
			if (reg_addr[0] == A_RED_OFS_HI[0]) begin
				ofs_hi_q[ofs_chan(reg_addr)] <= reg_wdata;
			end else begin
				ofs_lo_q[ofs_chan(reg_addr)] <=
					reg_wdata[OFS_LO_MSB:OFS_LO_LSB];
			end
		end
	end

	// Line total: staged high byte, PLL value moves on low write only
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lt_hi_q <= R_LT_HI[HI6_MSB:0];
			lt_q    <= {R_LT_HI[HI6_MSB:0], R_LT_LO};
		end else if (reg_wr) begin
			if (reg_addr == A_LT_HI) begin
				lt_hi_q <= reg_wdata[HI6_MSB:0];
			end
			if (reg_addr == A_LT_LO) begin
				lt_q <= {lt_hi_q, reg_wdata};
			end
		end
	end

	// Remaining plain control registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_q        <= R_PHASE[PH_W-1:0];
			coast_before_q <= R_COAST;
			coast_after_q  <= R_COAST;
			opt_q          <= R_PLL_OPT[OPT_MSB:0];
			rst_hi_q       <= R_RST_HI[HI6_MSB:0];
			rst_lo_q       <= R_RST_LO;
			clamp_w_q      <= R_CLAMP_W;
			cfg_q          <= R_COMP_CFG;
		end else if (reg_wr) begin
			unique case (reg_addr)
				A_PHASE:        phase_q        <= reg_wdata[PH_W-1:0];
				A_COAST_BEFORE: coast_before_q <= reg_wdata;
				A_COAST_AFTER:  coast_after_q  <= reg_wdata;
				A_PLL_OPT:      opt_q          <= reg_wdata[OPT_MSB:0];
				A_RST_HI:       rst_hi_q       <= reg_wdata[HI6_MSB:0];
				A_RST_LO:       rst_lo_q       <= reg_wdata;
				A_CLAMP_W:      clamp_w_q      <= reg_wdata;
				A_COMP_CFG:     cfg_q          <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read path; unmapped addresses and bits outside narrow fields read as zero; A_COMP_CFG reads back all eight bits
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			rdata_q <= '0;
			if (is_ofs(reg_addr)) begin
				if (reg_addr[0] == A_RED_OFS_HI[0]) begin
					rdata_q <= ofs_hi_q[ofs_chan(reg_addr)];
				end else begin
					rdata_q[OFS_LO_MSB:OFS_LO_LSB] <=
						ofs_lo_q[ofs_chan(reg_addr)];
				end
			end else begin
				unique case (reg_addr)
					A_LT_HI:        rdata_q <= {2'h0, lt_hi_q};
					A_LT_LO:        rdata_q <= lt_q[7:0];
					A_PHASE:        rdata_q <= {2'h0, phase_q};
					A_COAST_BEFORE: rdata_q <= coast_before_q;
					A_COAST_AFTER:  rdata_q <= coast_after_q;
					A_PLL_OPT:      rdata_q <= {3'h0, opt_q};
					A_RST_HI:       rdata_q <= {2'h0, rst_hi_q};
					A_RST_LO:       rdata_q <= rst_lo_q;
					A_CLAMP_W:      rdata_q <= clamp_w_q;
					A_COMP_CFG:     rdata_q <= cfg_q;
					default:        rdata_q <= '0;
				endcase
			end
		end
	end

	assign reg_rdata = rdata_q;

	// Offset path per channel; both modes share one register stage
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		logic [OFS_W-1:0]  word;
		logic signed [11:0] sum;
		assign word = {ofs_hi_q[c], ofs_lo_q[c]};
		// 0x200 is zero offset, so the word is excess-512 signed
		assign sum = $signed({2'b00, sample_in[c]})
			+ $signed({2'b00, word}) - $signed({2'b00, OFS_MID});

		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				dac_offset[c] <= R_OFS_HI;
				sample_out[c] <= '0;
			end else begin
				// Mid DAC while the digital adder does the work
				dac_offset[c] <= comp_on ? R_OFS_HI : ofs_hi_q[c];
				if (sample_in_valid) begin
					if (!comp_on) begin
						sample_out[c] <= sample_in[c];
					end else if (sum < 0) begin
						sample_out[c] <= '0;
					end else if (sum > $signed({2'b00, SMP_MAX})) begin
						sample_out[c] <= SMP_MAX;
					end else begin
						sample_out[c] <= sum[SMP_W-1:0];
					end
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sample_out_valid <= 1'b0;
		end else begin
			sample_out_valid <= sample_in_valid;
		end
	end

	// PLL settings
	assign pll_line_total       = lt_q;
	assign pll_phase            = phase_q;
	assign pixel_clock_external = opt_q[OPT_EXT_CLK];
	assign pixel_clock_invert   = opt_q[OPT_INV_EN]
		& clock_invert_input;
	assign pixel_tick = opt_q[OPT_EXT_CLK]
		? external_pixel_clock_input : dpll_pixel_tick;

	// Sync edge detection
	logic hs_q;
	logic raw_hs_q;
	logic vs_q;
	logic hs_lead;
	logic hs_trail;
	logic raw_trail;
	logic vs_rise;
	logic vs_fall;
	logic line_tick;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hs_q     <= 1'b0;
			raw_hs_q <= 1'b0;
			vs_q     <= 1'b0;
		end else begin
			hs_q     <= hsync;
			raw_hs_q <= raw_hsync;
			vs_q     <= vsync;
		end
	end

	assign hs_lead   = hsync & ~hs_q;
	assign hs_trail  = ~hsync & hs_q;
	assign raw_trail = ~raw_hsync & raw_hs_q;
	assign vs_rise   = vsync & ~vs_q;
	assign vs_fall   = ~vsync & vs_q;
	assign line_tick = opt_q[OPT_LOCK_LEAD] ? hs_lead : hs_trail;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pll_lock_pulse <= 1'b0;
		end else begin
			pll_lock_pulse <= line_tick;
		end
	end

	// Internal coast: pre-coast predicted from last frame's line count
	logic [LINE_W-1:0] line_cnt_q;
	logic [LINE_W-1:0] frame_lines_q;
	logic [7:0]        post_cnt_q;
	logic [LINE_W:0]   pre_mark;
	logic              pre_act;
	logic              int_coast;
	logic              ext_coast;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			line_cnt_q    <= '0;
			frame_lines_q <= '0;
		end else if (vs_rise) begin
			frame_lines_q <= line_cnt_q;
			line_cnt_q    <= '0;
		end else if (line_tick && (line_cnt_q != '1)) begin
			line_cnt_q <= line_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			post_cnt_q <= '0;
		end else if (vs_fall) begin
			post_cnt_q <= coast_after_q;
		end else if (line_tick && (post_cnt_q != '0)) begin
			post_cnt_q <= post_cnt_q - 1'b1;
		end
	end

	// First frame has no line count yet, so no pre-coast until learned
	assign pre_mark = {1'b0, line_cnt_q}
		+ {{(LINE_W-7){1'b0}}, coast_before_q};
	assign pre_act  = (frame_lines_q != '0)
		&& (pre_mark >= {1'b0, frame_lines_q});
	assign int_coast = vsync | pre_act | (post_cnt_q != '0);
	assign ext_coast = ext_coast_in ^ opt_q[OPT_COAST_POL];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pll_coast <= 1'b0;
		end else begin
			pll_coast <= opt_q[OPT_EXT_COAST] ? ext_coast : int_coast;
		end
	end

	// DC restore clamp and black level window, counted in pixels
	poc_clamp_e        st_q;
	logic [LT_W-1:0]   pix_cnt_q;
	logic [7:0]        clamp_cnt_q;
	logic [LT_W-1:0]   restore_start;

	assign restore_start = {rst_hi_q, rst_lo_q};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q            <= POC_IDLE;
			pix_cnt_q       <= '0;
			clamp_cnt_q     <= '0;
			blc_start_pulse <= 1'b0;
		end else begin
			blc_start_pulse <= 1'b0;
			if (raw_trail) begin
				st_q      <= POC_WAIT;
				pix_cnt_q <= '0;
			end else begin
				unique case (st_q)
					POC_IDLE: ;
					POC_WAIT: begin
						if (pixel_tick) begin
							if (pix_cnt_q == restore_start) begin
								blc_start_pulse <= 1'b1;
								clamp_cnt_q     <= clamp_w_q;
								st_q <= (clamp_w_q == '0)
									? POC_IDLE : POC_CLAMP;
							end else begin
								pix_cnt_q <= pix_cnt_q + 1'b1;
							end
						end
					end
					POC_CLAMP: begin
						if (pixel_tick) begin
							clamp_cnt_q <= clamp_cnt_q - 1'b1;
							if (clamp_cnt_q == 8'h01) begin
								st_q <= POC_IDLE;
							end
						end
					end
					default: st_q <= POC_IDLE;
				endcase
			end
		end
	end

	assign clamp_connect = (st_q == POC_CLAMP);

endmodule

`default_nettype wire

// ---- testbench/poc_ctrl_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module poc_ctrl_sva
	import poc_pkg::*;
(
	input wire logic             clk_sys,
	input wire logic             rst_n,
	input wire logic [7:0]       reg_addr,
	input wire logic [7:0]       reg_wdata,
	input wire logic             reg_wr,
	input wire logic             reg_rd,
	input wire logic [7:0]       reg_rdata,
	input wire logic             hsync,
	input wire logic             ext_coast_in,
	input wire logic             clock_invert_input,
	input wire logic             dpll_pixel_tick,
	input wire logic             external_pixel_clock_input,
	input wire logic             sample_in_valid,
	input wire logic             sample_out_valid,
	input wire logic [LT_W-1:0]  pll_line_total,
	input wire logic [PH_W-1:0]  pll_phase,
	input wire logic             pll_lock_pulse,
	input wire logic             pll_coast,
	input wire logic             pixel_clock_invert,
	input wire logic             pixel_clock_external,
	input wire logic             pixel_tick,
	input wire logic             clamp_connect
);
	logic [7:0] opt_q;
	logic [7:0] cw_q;
	logic       ext_lvl;
	// Shadow copies so the checker knows the mode without peeking inside
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) opt_q <= R_PLL_OPT;
		else if (reg_wr && reg_addr == A_PLL_OPT) opt_q <= reg_wdata;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) cw_q <= R_CLAMP_W;
		else if (reg_wr && reg_addr == A_CLAMP_W) cw_q <= reg_wdata;
	end
	assign ext_lvl = ext_coast_in ^ opt_q[OPT_COAST_POL];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_wr(a);
		reg_wr && reg_addr == a;
	endsequence
	sequence s_rd(a);
		reg_rd && reg_addr == a;
	endsequence
	property p_phase;
		s_wr(A_PHASE) |=> {2'h0, pll_phase} == ($past(reg_wdata) & 8'h3f);
	endproperty
	a_phase: assert property (p_phase) else $error("phase not loaded");
	property p_lt_hold;
		s_wr(A_LT_HI) |=> $stable(pll_line_total);
	endproperty
	a_lt_hold: assert property (p_lt_hold) else $error("total moved");
	property p_lt_load;
		s_wr(A_LT_LO) |=> pll_line_total[7:0] == $past(reg_wdata);
	endproperty
	a_lt_load: assert property (p_lt_load) else $error("total low");
	property p_lo_read;
		s_rd(A_RED_OFS_LO) |=> reg_rdata[5:0] == 6'h00;
	endproperty
	a_lo_read: assert property (p_lo_read) else $error("low bits");
	property p_tick;
		pixel_tick == (pixel_clock_external ? external_pixel_clock_input
			: dpll_pixel_tick);
	endproperty
	a_tick: assert property (p_tick) else $error("tick source");
	property p_inv;
		pixel_clock_invert == (opt_q[OPT_INV_EN] && clock_invert_input);
	endproperty
	a_inv: assert property (p_inv) else $error("invert gate");
	property p_coast_ext;
		opt_q[OPT_EXT_COAST] |=> pll_coast == $past(ext_lvl);
	endproperty
	a_coast_ext: assert property (p_coast_ext) else $error("ext coast");
	property p_lock;
		(opt_q[OPT_LOCK_LEAD] ? $rose(hsync) : $fell(hsync)) |=> pll_lock_pulse;
	endproperty
	a_lock: assert property (p_lock) else $error("no lock pulse");
	property p_clamp0;
		!clamp_connect && cw_q == 8'h00 |=> !clamp_connect;
	endproperty
	a_clamp0: assert property (p_clamp0) else $error("clamp on");
	property p_smp;
		sample_in_valid |=> sample_out_valid;
	endproperty
	a_smp: assert property (p_smp) else $error("sample delay");
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
	$display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench
	import poc_pkg::*;
;
	logic                         clk_sys = 1'b0;
	logic                         rst_n, reg_wr, reg_rd;
	logic [7:0]                   reg_addr, reg_wdata, reg_rdata;
	logic                         hsync, raw_hsync, vsync, ext_coast_in;
	logic                         clock_invert_input, dpll_pixel_tick;
	logic                         external_pixel_clock_input;
	logic                         sample_in_valid, sample_out_valid;
	logic [NUM_CH-1:0][SMP_W-1:0] sample_in, sample_out;
	logic [NUM_CH-1:0][7:0]       dac_offset;
	logic [LT_W-1:0]              pll_line_total;
	logic [PH_W-1:0]              pll_phase;
	logic                         pll_lock_pulse, pll_coast;
	logic                         pixel_clock_invert, pixel_clock_external;
	logic                         pixel_tick, blc_start_pulse, clamp_connect;
	int                           err_total, checks, cyc, n, p1, p2;
	localparam logic [7:0] RV [16] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h80,
		8'h00, 8'h06, 8'h98, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h02,
		8'h10, 8'h40};

	poc_ctrl DUT (.*);

	always #25 clk_sys = ~clk_sys;

	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask

	task automatic ofs(logic [7:0] h, logic [7:0] l);
		for (int c = 0; c < 3; c++) begin
			wr(8'(A_RED_OFS_HI + 2 * c), h);
			wr(8'(A_RED_OFS_LO + 2 * c), l);
		end
	endtask

	task automatic smp(logic [9:0] v, logic [9:0] e);
		@(posedge clk_sys);
		sample_in       <= {3{v}};
		sample_in_valid <= 1'b1;
		@(posedge clk_sys);
		sample_in_valid <= 1'b0;
		#1;
		`CHK(sample_out, {3{e}})
	endtask

	// Counts lock pulses seen in a short window after an hsync change
	task automatic hs(logic v, output int k);
		@(posedge clk_sys);
		hsync <= v;
		k = 0;
		repeat (4) begin
			@(posedge clk_sys);
			#1;
			k += int'(pll_lock_pulse);
		end
	endtask

	task automatic clamp(logic [7:0] w, logic [7:0] s, output int p);
		int c;
		wr(A_RST_LO, s);
		wr(A_CLAMP_W, w);
		@(posedge clk_sys);
		raw_hsync       <= 1'b1;
		dpll_pixel_tick <= 1'b1;
		@(posedge clk_sys);
		raw_hsync <= 1'b0;
		p = 0;
		c = 0;
		for (int i = 1; i < 40; i++) begin
			@(posedge clk_sys);
			#1;
			if (blc_start_pulse === 1'b1) p = i;
			c += int'(clamp_connect);
		end
		dpll_pixel_tick <= 1'b0;
		`CHK(c, int'(w))
	endtask

	task automatic t_regs;
		for (int i = 0; i < 16; i++) rd(8'(8'h18 + i), RV[i]);
		rd(8'h00, 8'h00);
		rd(8'h28, 8'h00);
		`CHK(dac_offset, {3{8'h80}})
		wr(A_LT_HI, 8'hc5);
		`CHK(pll_line_total, 14'h0698)
		rd(A_LT_HI, 8'h05);
		wr(A_LT_LO, 8'h20);
		`CHK(pll_line_total, 14'h0520)
		wr(A_PHASE, 8'hff);
		`CHK(pll_phase, 6'h3f)
		rd(A_PHASE, 8'h3f);
		$display("test registers done");
	endtask

	task automatic t_offset;
		ofs(8'h81, 8'hff);
		rd(A_BLU_OFS_LO, 8'hc0);
		wr(A_COMP_CFG, 8'h41);
		@(posedge clk_sys);
		#1;
		`CHK(dac_offset, {3{8'h81}})
		smp(10'h155, 10'h155);
		wr(A_COMP_CFG, 8'h40);
		ofs(8'h81, 8'h00);
		smp(10'h100, 10'h104);
		ofs(8'h80, 8'h00);
		smp(10'h123, 10'h123);
		ofs(8'hff, 8'hc0);
		smp(10'h300, 10'h3ff);
		ofs(8'h00, 8'h00);
		smp(10'h100, 10'h000);
		$display("test offset done");
	endtask

	task automatic t_pll;
		for (int i = 0; i < 2; i++) begin
			wr(A_PLL_OPT, i ? 8'hff : 8'h00);
			rd(A_PLL_OPT, i ? 8'h1f : 8'h00);
			@(posedge clk_sys);
			clock_invert_input         <= 1'b1;
			dpll_pixel_tick            <= 1'b1;
			external_pixel_clock_input <= 1'b0;
			#1;
			`CHK(pixel_clock_invert, i[0])
			`CHK(pixel_tick, ~i[0])
			wr(A_PLL_OPT, 8'(i));
			hs(1'b1, n);
			`CHK(n, i)
			hs(1'b0, n);
			`CHK(n, 1 - i)
		end
		dpll_pixel_tick <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wr(A_PLL_OPT, i[1] ? 8'h0c : 8'h04);
			ext_coast_in <= i[0];
			repeat (2) @(posedge clk_sys);
			#1;
			`CHK(pll_coast, i[0] ^ i[1])
		end
		// Reset forgets the learned frame length, else pre-coast masks post
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		`CHK(pll_coast, 1'b0)
		wr(A_PLL_OPT, 8'h00);
		wr(A_COAST_AFTER, 8'h02);
		vsync <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK(pll_coast, 1'b1)
		vsync <= 1'b0;
		hs(1'b1, n);
		hs(1'b0, n);
		`CHK(pll_coast, 1'b1)
		hs(1'b1, n);
		hs(1'b0, n);
		`CHK(pll_coast, 1'b0)
		$display("test pll done");
	endtask

	task automatic t_clamp;
		clamp(8'h05, 8'h03, p1);
		clamp(8'h05, 8'h06, p2);
		`CHK(p1 > 0, 1'b1)
		`CHK(p2 - p1, 3)
		clamp(8'h00, 8'h03, p1);
		$display("test clamp done");
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Generous ceiling; the full sequence needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			print_verdict;
		end
	end

	initial begin
		{rst_n, reg_wr, reg_rd, hsync, raw_hsync, vsync} = '0;
		{ext_coast_in, clock_invert_input, dpll_pixel_tick} = '0;
		{external_pixel_clock_input, sample_in_valid} = '0;
		{reg_addr, reg_wdata, sample_in} = '0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_regs;
		t_offset;
		t_pll;
		t_clamp;
		print_verdict;
	end
endmodule

bind poc_ctrl poc_ctrl_sva u_sva (.*);
`default_nettype wire
